//--- pkg/cils_pkg.sv
// Package with register numbers, field positions and reset values for the interrupt state block.
package cils_pkg;
  // ----------------------------------------
  // Register selects within register number 12
  // ----------------------------------------
  localparam logic [4:0] CILS_REG_NUM = 5'h0C;
  localparam logic [2:0] CILS_SEL_STATUS = 3'h0;
  localparam logic [2:0] CILS_SEL_INTERRUPT_VECTOR_CONTROL = 3'h1;
  localparam logic [2:0] CILS_SEL_SHADOW = 3'h2;
  localparam logic [2:0] CILS_SEL_MAP = 3'h3;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CILS_IE_BIT = 0;
  localparam int CILS_EXL_BIT = 1;
  localparam int CILS_ERL_BIT = 2;
  localparam int CILS_UM_BIT = 4;
  localparam int CILS_BEV_BIT = 22;
  localparam int CILS_VS_LO = 5;
  localparam int CILS_VS_HI = 9;
  localparam int CILS_CSS_LO = 0;
  localparam int CILS_PSS_LO = 6;
  localparam int CILS_ESS_LO = 12;
  localparam int CILS_EXT_CTRL_SHADOW_SET_LO = 18;
  localparam int CILS_HSS_LO = 26;
  // ----------------------------------------
  // Values
  // ----------------------------------------
  localparam logic [3:0] CILS_HSS_VALUE = 4'h3;
  localparam logic [4:0] CILS_VS_RESET = 5'h00;
  localparam logic [3:0] CILS_SET_RESET = 4'h0;
  localparam logic [31:0] CILS_MAP_RESET = 32'h0000_0000;
  localparam logic [31:0] CILS_BASE_RESET = 32'h0000_0000;
  localparam int CILS_SPACING_SHIFT = 5;
  localparam int CILS_SET_W = 4;
  typedef enum logic [1:0] {
    cils_src_ess,
    cils_src_eic,
    cils_src_map
  } cils_src_e;
endpackage

//--- hw/cils_spacing.sv
// Vector address generator from spacing code and vector number.
`timescale 1ns/10ps
`default_nettype none
module cils_spacing
  import cils_pkg::*;
(
  input wire logic [4:0] vs,
  input wire logic [5:0] vector_num,
  input wire logic [31:0] base_addr,
  output logic [31:0] vector_addr
);
  // The offset is the vector number times the spacing code times 32, which is a shift when the code is one-hot.
  logic [31:0] offset;
  always_comb begin
    offset = 32'({vs, 5'h00}) * 32'(vector_num);
    vector_addr = base_addr + offset;
  end
endmodule
`default_nettype wire

//--- hw/cils_set_select.sv
// Selects the new current shadow set on an exception or interrupt.
`timescale 1ns/10ps
`default_nettype none
module cils_set_select
  import cils_pkg::*;
(
  input wire logic is_interrupt,
  input wire logic vectored_intr_flag,
  input wire logic ext_ctrl_mode_flag,
  input wire logic [4:0] vs,
  input wire logic [3:0] exception_shadow_set,
  input wire logic [3:0] ext_ctrl_shadow_set,
  input wire logic [31:0] vector_shadow_map,
  input wire logic [5:0] vector_num,
  output logic [3:0] new_set
);
  cils_src_e src;
  always_comb begin
    if (!is_interrupt || !vectored_intr_flag || vs == CILS_VS_RESET) begin
      src = cils_src_ess;
    end else if (ext_ctrl_mode_flag) begin
      src = cils_src_eic;
    end else begin
      src = cils_src_map;
    end
    case (src)
      cils_src_eic: new_set = ext_ctrl_shadow_set;
      cils_src_map: new_set = vector_shadow_map[{vector_num[2:0], 2'b00} +: CILS_SET_W];
      default: new_set = exception_shadow_set;
    endcase
  end
endmodule
`default_nettype wire

//--- hw/cils_ctrl.sv
// Exception level, interrupt enable, vector spacing and shadow set control state.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Any exception except hard reset, soft reset, NMI or cache error sets exception level.
// - Exception level one forces kernel mode and disables all interrupts.
// - Exception under exception level leaves return pc, delay flag, shadow control alone.
// - Status bit 0 is master enable for software and hardware interrupts.
// - Dedicated disable and enable instructions clear or set the master enable.
// - Spacing field bits 9 to 5 selects 0, 32, 64, 128, 256 or 512 bytes.
// - Interrupt control bits outside spacing field read as zero.
// - Exceptions and non-vectored interrupts load current set from exception set field.
// - Vectored interrupts in external controller mode take set from the controller.
// - Read-only highest-set field bits 29 to 26 reports implemented shadow sets.
// - External set field bits 21 to 18 loads per request and picks set.
// - Exception set field bits 15 to 12 picks set for non-vectored entries.
// - Entry copies current set to previous; return restores it when error level and boot vector clear.
// - No set update on error-level exceptions, debug entry, or under exception level/boot.
// - Reset, soft reset, NMI, cache error set error level; kernel, interrupts off.
module cils_ctrl
  import cils_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic reg_wr,
  input wire logic [4:0] reg_num,
  input wire logic [2:0] reg_sel,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  input wire logic exc_take,
  input wire logic exc_is_interrupt,
  input wire logic exc_sets_error,
  input wire logic exc_no_level,
  input wire logic debug_entry,
  input wire logic exception_return_instr,
  input wire logic intr_off_instruction,
  input wire logic intr_on_instruction,
  input wire logic vectored_intr_flag,
  input wire logic ext_ctrl_mode_flag,
  input wire logic [3:0] ext_ctrl_shadow_set,
  input wire logic [5:0] vector_num,
  input wire logic [31:0] vector_base,
  input wire logic debug_mode,
  output logic exception_level,
  output logic error_level,
  output logic interrupt_master_enable,
  output logic boot_vector_select,
  output logic kernel_mode,
  output logic intr_enabled,
  output logic save_context,
  output logic [4:0] vector_spacing,
  output logic [3:0] current_shadow_set,
  output logic [3:0] previous_shadow_set,
  output logic [31:0] vector_addr
);
  // ----------------------------------------
  // Decode and local state
  // ----------------------------------------
  logic user_mode;
  logic [3:0] exception_shadow_set;
  logic [3:0] eic_set;
  logic [31:0] vector_shadow_map;
  logic [3:0] next_css;
  logic [31:0] next_vaddr;
  logic wr_status;
  logic wr_interrupt_vector_control;
  logic wr_shadow;
  logic wr_map;
  logic entry_updates;
  logic next_exl;
  logic next_erl;
  logic next_um;

  always_comb begin
    wr_status = 1'b0;
    wr_interrupt_vector_control = 1'b0;
    wr_shadow = 1'b0;
    wr_map = 1'b0;
    if (reg_wr && reg_num == CILS_REG_NUM) begin
      if (reg_sel == CILS_SEL_STATUS) begin
        wr_status = 1'b1;
      end else if (reg_sel == CILS_SEL_INTERRUPT_VECTOR_CONTROL) begin
        wr_interrupt_vector_control = 1'b1;
      end else if (reg_sel == CILS_SEL_SHADOW) begin
        wr_shadow = 1'b1;
      end else if (reg_sel == CILS_SEL_MAP) begin
        wr_map = 1'b1;
      end
    end
  end

  // Set selection is only allowed from a clean state at entry.
  always_comb begin
    entry_updates = exc_take && !exc_sets_error && !debug_entry && !exception_level && !error_level
      && !boot_vector_select;
  end

  cils_set_select u_sel (
    .is_interrupt(exc_is_interrupt),
    .vectored_intr_flag(vectored_intr_flag),
    .ext_ctrl_mode_flag(ext_ctrl_mode_flag),
    .vs(vector_spacing),
    .exception_shadow_set(exception_shadow_set),
    .ext_ctrl_shadow_set(ext_ctrl_shadow_set),
    .vector_shadow_map(vector_shadow_map),
    .vector_num(vector_num),
    .new_set(next_css)
  );

  cils_spacing u_space (
    .vs(vector_spacing),
    .vector_num(vector_num),
    .base_addr(vector_base),
    .vector_addr(next_vaddr)
  );

  // ----------------------------------------
  // Status levels and enable
  // ----------------------------------------
  always_comb begin
    next_exl = exception_level;
    next_erl = error_level;
    next_um = user_mode;
    if (wr_status) begin
      next_exl = reg_wdata[CILS_EXL_BIT];
      next_erl = reg_wdata[CILS_ERL_BIT];
      next_um = reg_wdata[CILS_UM_BIT];
    end
    if (exception_return_instr) begin
      if (error_level) begin
        next_erl = 1'b0;
      end else begin
        next_exl = 1'b0;
      end
    end
    if (exc_take && !debug_entry) begin
      if (exc_sets_error) begin
        next_erl = 1'b1;
      end else if (!exc_no_level) begin
        next_exl = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      exception_level <= 1'b0;
      error_level <= 1'b1;
      user_mode <= 1'b0;
      boot_vector_select <= 1'b1;
    end else begin
      exception_level <= next_exl;
      error_level <= next_erl;
      user_mode <= next_um;
      if (wr_status) begin
        boot_vector_select <= reg_wdata[CILS_BEV_BIT];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      interrupt_master_enable <= 1'b0;
    end else if (intr_off_instruction) begin
      interrupt_master_enable <= 1'b0;
    end else if (intr_on_instruction) begin
      interrupt_master_enable <= 1'b1;
    end else if (wr_status) begin
      interrupt_master_enable <= reg_wdata[CILS_IE_BIT];
    end
  end

  // Derived mode flags are registered from the next levels so that they change in the same cycle as the levels.
  always_ff @(posedge mclk) begin
    if (srst) begin
      kernel_mode <= 1'b1;
      intr_enabled <= 1'b0;
      save_context <= 1'b0;
    end else begin
      kernel_mode <= !next_um || next_exl || next_erl;
      intr_enabled <= interrupt_master_enable && !next_exl && !next_erl && !debug_mode;
      save_context <= exc_take && !exception_level;
    end
  end

  // ----------------------------------------
  // Vector spacing and address
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      vector_spacing <= CILS_VS_RESET;
    end else if (wr_interrupt_vector_control) begin
      vector_spacing <= reg_wdata[CILS_VS_HI:CILS_VS_LO];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      vector_addr <= CILS_BASE_RESET;
    end else begin
      vector_addr <= next_vaddr;
    end
  end

  // ----------------------------------------
  // Shadow set control
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      eic_set <= CILS_SET_RESET;
    end else if (exc_take && exc_is_interrupt) begin
      eic_set <= ext_ctrl_shadow_set;
    end
  end

  // Software cannot write the current set directly; only through previous and a return.
  always_ff @(posedge mclk) begin
    if (srst) begin
      current_shadow_set <= CILS_SET_RESET;
      previous_shadow_set <= CILS_SET_RESET;
      exception_shadow_set <= CILS_SET_RESET;
    end else begin
      if (wr_shadow) begin
        exception_shadow_set <= reg_wdata[CILS_ESS_LO +: CILS_SET_W];
        previous_shadow_set <= reg_wdata[CILS_PSS_LO +: CILS_SET_W];
      end
      if (entry_updates) begin
        previous_shadow_set <= current_shadow_set;
        current_shadow_set <= next_css;
      end else if (exception_return_instr && !error_level && !boot_vector_select) begin
        current_shadow_set <= previous_shadow_set;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      vector_shadow_map <= CILS_MAP_RESET;
    end else if (wr_map) begin
      vector_shadow_map <= reg_wdata;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= 32'h0000_0000;
      if (reg_num == CILS_REG_NUM) begin
        if (reg_sel == CILS_SEL_STATUS) begin
          reg_rdata[CILS_IE_BIT] <= interrupt_master_enable;
          reg_rdata[CILS_EXL_BIT] <= exception_level;
          reg_rdata[CILS_ERL_BIT] <= error_level;
          reg_rdata[CILS_UM_BIT] <= user_mode;
          reg_rdata[CILS_BEV_BIT] <= boot_vector_select;
        end else if (reg_sel == CILS_SEL_INTERRUPT_VECTOR_CONTROL) begin
          reg_rdata[CILS_VS_HI:CILS_VS_LO] <= vector_spacing;
        end else if (reg_sel == CILS_SEL_SHADOW) begin
          reg_rdata[CILS_HSS_LO +: CILS_SET_W] <= CILS_HSS_VALUE;
          reg_rdata[CILS_EXT_CTRL_SHADOW_SET_LO +: CILS_SET_W] <= eic_set;
          reg_rdata[CILS_ESS_LO +: CILS_SET_W] <= exception_shadow_set;
          reg_rdata[CILS_PSS_LO +: CILS_SET_W] <= previous_shadow_set;
          reg_rdata[CILS_CSS_LO +: CILS_SET_W] <= current_shadow_set;
        end else if (reg_sel == CILS_SEL_MAP) begin
          reg_rdata <= vector_shadow_map;
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- dv/cils_ctrl_sva.sv
// Concurrent checks on the interrupt state block ports.
`timescale 1ns/10ps
`default_nettype none
module cils_ctrl_sva
  import cils_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic reg_wr,
  input wire logic [4:0] reg_num,
  input wire logic [2:0] reg_sel,
  input wire logic [31:0] reg_rdata,
  input wire logic exc_take,
  input wire logic exc_sets_error,
  input wire logic exc_no_level,
  input wire logic debug_entry,
  input wire logic exception_return_instr,
  input wire logic intr_off_instruction,
  input wire logic intr_on_instruction,
  input wire logic debug_mode,
  input wire logic [5:0] vector_num,
  input wire logic [31:0] vector_base,
  input wire logic exception_level,
  input wire logic error_level,
  input wire logic interrupt_master_enable,
  input wire logic boot_vector_select,
  input wire logic kernel_mode,
  input wire logic intr_enabled,
  input wire logic save_context,
  input wire logic [4:0] vector_spacing,
  input wire logic [3:0] current_shadow_set,
  input wire logic [3:0] previous_shadow_set,
  input wire logic [31:0] vector_addr
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  // A blocked entry must leave both set fields alone.
  logic blk;
  assign blk = exception_level | error_level | boot_vector_select | exc_sets_error | debug_entry;
  a_exc_sets_level: assert property (exc_take && !exc_no_level && !exc_sets_error && !debug_entry |=> exception_level)
    else $error("exception level not set");
  // Mode flags are registered from the next levels, so they line up with the level bits in the same cycle.
  a_level_kernel_off: assert property (exception_level |-> kernel_mode && !intr_enabled)
    else $error("level one not kernel or enabled");
  a_master_enable: assert property (1'b1 |=> intr_enabled == ($past(interrupt_master_enable) && !exception_level
    && !error_level && !$past(debug_mode)))
    else $error("interrupt enable mismatch");
  a_save_context: assert property (1'b1 |=> save_context == ($past(exc_take) && !$past(exception_level)))
    else $error("context save pulse wrong");
  a_disable_wins: assert property (intr_off_instruction |=> !interrupt_master_enable)
    else $error("disable instruction ignored");
  a_enable_instr: assert property (intr_on_instruction && !intr_off_instruction |=> interrupt_master_enable)
    else $error("enable instruction ignored");
  a_interrupt_vector_control_zero: assert property (reg_num == CILS_REG_NUM && reg_sel == CILS_SEL_INTERRUPT_VECTOR_CONTROL
    |=> reg_rdata[31:10] == 22'h0 && reg_rdata[4:0] == 5'h00)
    else $error("unimplemented bits not zero");
  a_hss_field: assert property (reg_num == CILS_REG_NUM && reg_sel == CILS_SEL_SHADOW
    |=> reg_rdata[29:26] == CILS_HSS_VALUE)
    else $error("highest set field wrong");
  a_set_frozen: assert property (exc_take && blk && !reg_wr && !exception_return_instr
    |=> $stable(current_shadow_set) && $stable(previous_shadow_set))
    else $error("set changed on blocked entry");
  a_prev_copy: assert property (exc_take && !blk && !reg_wr |=> previous_shadow_set == $past(current_shadow_set))
    else $error("previous set not copied");
  a_error_level: assert property (exc_take && exc_sets_error |=> error_level)
    else $error("error level not set");
  a_vector_addr: assert property (1'b1 |=> vector_addr == $past(vector_base) + $past(vector_num)
    * ($past(vector_spacing) << 5))
    else $error("vector address wrong");
endmodule
`default_nettype wire

//--- dv/cils_eic_model.sv
// External interrupt controller model that supplies a shadow set per request.
`timescale 1ns/10ps
`default_nettype none
module cils_eic_model
  import cils_pkg::*;
(
  input wire logic mclk,
  input wire logic req,
  input wire logic [3:0] lat,
  input wire logic [3:0] req_set,
  output logic rdy,
  output logic [3:0] ext_ctrl_shadow_set
);
  logic [3:0] cnt = 4'h0;
  logic [3:0] junk = 4'h5;
  always_ff @(posedge mclk) begin
    junk <= ~junk + 4'h1;
    cnt <= req ? cnt + 4'h1 : 4'h0;
  end
  assign rdy = req && (cnt >= lat);
  // Outside a request the line wanders so that a stale sample is caught.
  assign ext_ctrl_shadow_set = !rdy ? junk : (req_set > CILS_HSS_VALUE) ? CILS_HSS_VALUE : req_set;
endmodule
`default_nettype wire

//--- dv/cils_ctrl_tb.sv
// Self-checking testbench for the interrupt state block.
`timescale 1ns/10ps
`default_nettype none
module cils_ctrl_tb
  import cils_pkg::*;
;
  logic mclk = 1'b0, srst = 1'b1, reg_wr = 1'b0, exc_take = 1'b0, exc_is_interrupt = 1'b0;
  logic exc_sets_error = 1'b0, exc_no_level = 1'b0, debug_entry = 1'b0, exception_return_instr = 1'b0;
  logic intr_off_instruction = 1'b0, intr_on_instruction = 1'b0, vectored_intr_flag = 1'b0;
  logic ext_ctrl_mode_flag = 1'b0, debug_mode = 1'b0, eic_req = 1'b0, eic_rdy;
  logic [4:0] reg_num = CILS_REG_NUM, vector_spacing;
  logic [2:0] reg_sel = 3'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, vector_base = 32'h0, vector_addr;
  logic [3:0] eic_set = 4'h0, ext_ctrl_shadow_set, current_shadow_set, previous_shadow_set;
  logic [5:0] vector_num = 6'h00;
  logic exception_level, error_level, interrupt_master_enable, boot_vector_select, kernel_mode, intr_enabled;
  int fails = 0, n_checks = 0;
  cils_eic_model u_cils_eic_model (.mclk(mclk), .req(eic_req), .lat(4'h4), .req_set(eic_set), .rdy(eic_rdy),
    .ext_ctrl_shadow_set(ext_ctrl_shadow_set));
  cils_ctrl u_cils_ctrl (.mclk, .srst, .reg_wr, .reg_num, .reg_sel, .reg_wdata, .reg_rdata, .exc_take,
    .exc_is_interrupt, .exc_sets_error, .exc_no_level, .debug_entry, .exception_return_instr,
    .intr_off_instruction, .intr_on_instruction, .vectored_intr_flag, .ext_ctrl_mode_flag, .ext_ctrl_shadow_set,
    .vector_num, .vector_base, .debug_mode, .exception_level, .error_level, .interrupt_master_enable,
    .boot_vector_select, .kernel_mode, .intr_enabled, .save_context(), .vector_spacing, .current_shadow_set,
    .previous_shadow_set, .vector_addr);
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("mismatch %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic wr(input logic [2:0] s, input logic [31:0] d);
    reg_wr <= 1'b1;
    reg_sel <= s;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [2:0] s, input logic [31:0] e);
    reg_sel <= s;
    repeat (2) @(posedge mclk);
    chk(reg_rdata, e, "read");
  endtask
  // The caller picks the kind; a reset-class entry also skips the level bit.
  task automatic exc(input logic i, input logic e);
    exc_is_interrupt <= i;
    exc_sets_error <= e;
    exc_no_level <= e;
    exc_take <= 1'b1;
    @(posedge mclk);
    exc_take <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask
  task automatic ret();
    exception_return_instr <= 1'b1;
    @(posedge mclk);
    exception_return_instr <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask
  task automatic t_reset();
    rd(CILS_SEL_STATUS, 32'h0040_0004);
    rd(CILS_SEL_SHADOW, 32'h0C00_0000);
    chk(kernel_mode, 1, "kernel");
    $display("t_reset done");
  endtask
  task automatic t_spacing();
    logic [4:0] code [6] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h08, 5'h10};
    logic [31:0] gap [6] = '{32'h0, 32'h20, 32'h40, 32'h80, 32'h100, 32'h200};
    vector_num <= 6'h03;
    vector_base <= 32'h0000_1000;
    for (int i = 0; i < 6; i++) begin
      wr(CILS_SEL_INTERRUPT_VECTOR_CONTROL, 32'hFFFF_FC1F | (32'(code[i]) << 5));
      rd(CILS_SEL_INTERRUPT_VECTOR_CONTROL, 32'(code[i]) << 5);
      chk(vector_addr, 32'h0000_1000 + 3 * gap[i], "vaddr");
    end
    reg_num <= 5'h0D;
    rd(CILS_SEL_INTERRUPT_VECTOR_CONTROL, 32'h0);
    reg_num <= CILS_REG_NUM;
    rd(3'h5, 32'h0);
    $display("t_spacing done");
  endtask
  task automatic t_ie();
    wr(CILS_SEL_STATUS, 32'h0000_0001);
    repeat (2) @(posedge mclk);
    chk(intr_enabled, 1, "ie on");
    debug_mode <= 1'b1;
    repeat (2) @(posedge mclk);
    chk(intr_enabled, 0, "debug off");
    debug_mode <= 1'b0;
    repeat (2) @(posedge mclk);
    chk(intr_enabled, 1, "debug back");
    intr_off_instruction <= 1'b1;
    intr_on_instruction <= 1'b1;
    @(posedge mclk);
    intr_off_instruction <= 1'b0;
    intr_on_instruction <= 1'b0;
    repeat (3) @(posedge mclk);
    chk(intr_enabled, 0, "ie off");
    intr_on_instruction <= 1'b1;
    @(posedge mclk);
    intr_on_instruction <= 1'b0;
    repeat (3) @(posedge mclk);
    chk(interrupt_master_enable, 1, "ie back");
    $display("t_ie done");
  endtask
  task automatic t_exc();
    wr(CILS_SEL_SHADOW, 32'h0000_2000);
    rd(CILS_SEL_SHADOW, 32'h0C00_2000);
    exc(1'b0, 1'b0);
    chk({exception_level, kernel_mode, intr_enabled}, 3'b110, "level");
    chk({current_shadow_set, previous_shadow_set}, 8'h20, "sets");
    wr(CILS_SEL_SHADOW, 32'h0000_1000);
    exc(1'b0, 1'b0);
    chk(current_shadow_set, 2, "nested");
    ret();
    chk({exception_level, intr_enabled, current_shadow_set}, 6'h10, "return");
    $display("t_exc done");
  endtask
  task automatic t_eic();
    int k = 0;
    vectored_intr_flag <= 1'b1;
    ext_ctrl_mode_flag <= 1'b1;
    eic_set <= 4'h3;
    eic_req <= 1'b1;
    @(posedge mclk);
    while (eic_rdy !== 1'b1) begin
      k++;
      if (k > 20) begin
        fails++;
        tally_and_finish();
      end
      @(posedge mclk);
    end
    exc(1'b1, 1'b0);
    eic_req <= 1'b0;
    chk({current_shadow_set, previous_shadow_set}, 8'h30, "eic");
    rd(CILS_SEL_SHADOW, 32'h0C0C_1003);
    ret();
    vectored_intr_flag <= 1'b0;
    exc(1'b1, 1'b0);
    chk(current_shadow_set, 1, "nonvec");
    ret();
    $display("t_eic done");
  endtask
  task automatic t_err();
    wr(CILS_SEL_SHADOW, 32'h0000_1080);
    exc(1'b0, 1'b1);
    chk({error_level, exception_level, kernel_mode, intr_enabled}, 4'hA, "err");
    chk({current_shadow_set, previous_shadow_set}, 8'h02, "err sets");
    ret();
    chk({error_level, current_shadow_set}, 5'h00, "err ret");
    debug_entry <= 1'b1;
    exc(1'b0, 1'b0);
    debug_entry <= 1'b0;
    chk({exception_level, current_shadow_set, previous_shadow_set}, 9'h002, "debug entry");
    $display("t_err done");
  endtask
  initial begin
    forever #2 mclk = ~mclk;
  end
  initial begin
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    t_reset();
    t_spacing();
    t_ie();
    t_exc();
    t_eic();
    t_err();
    tally_and_finish();
  end
endmodule
bind cils_ctrl cils_ctrl_sva u_cils_ctrl_sva (.mclk, .srst, .reg_wr, .reg_num, .reg_sel, .reg_rdata, .exc_take,
  .exc_sets_error, .exc_no_level, .debug_entry, .exception_return_instr, .intr_off_instruction,
  .intr_on_instruction, .debug_mode, .vector_num, .vector_base, .exception_level, .error_level,
  .interrupt_master_enable, .boot_vector_select, .kernel_mode, .intr_enabled, .save_context, .vector_spacing,
  .current_shadow_set, .previous_shadow_set, .vector_addr);
`default_nettype wire
